// >>> hw/ascr_config_register.sv
// Overview of operation
// - Twelve-bit configuration word, write only, never read back.
// - Host drives serial input; device samples it on falling serial clock.
// - Word shifted in applies to next conversion while result shifts out.
// - Only first twelve falling edges after select falls load the word.
// - Word goes most significant bit first; first bit lands in bit 11.
// - Fixed field layout: gate, sequencer, address, power, pattern, span, coding.
// - Gate bit 1 loads the other eleven bits; 0 keeps word unchanged.
// - Sequencer bit with pattern select picks sequencing and pattern-register load.
// - Channel address taken on fourteenth falling edge; picks next input or sequence end.
// - Output frame carries result's channel address before twelve result bits.
// - Input mux moves to next channel on fourteenth falling edge.
// - Span bit 0 gives twice reference, 1 gives reference, next conversion.
// - Coding bit 0 gives twos complement, 1 straight binary, next conversion.
// - Power-mode bits at positions 5 and 4 choose the power mode.
// - 11 normal, 10 full shutdown, 01 auto shutdown with wake time; no 00.
// - Channel address value equals the selected input channel number.
// - Modes 00 single, 01 pattern load, 10 continue, 11 consecutive from zero.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Sample buffer between the converter front end and the serial frame
module ascr_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
)(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	wire full_w;
	wire empty_w;
	wire push_w;
	wire pop_w;

	// Extra pointer bit tells full from empty
	assign full_w = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty_w = (wr_ptr_r == rd_ptr_r);
	assign push_w = in_valid_i && !full_w;
	assign pop_w = out_ready_i && !empty_w;
	assign in_ready_o = !full_w;
	assign out_valid_o = !empty_w;
	assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

	// Storage is not reset; only the pointers carry state
	always_ff @(posedge sys_clk_i)
	begin
		if (push_w)
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_r + (AW+1)'(push_w);
			rd_ptr_r <= rd_ptr_r + (AW+1)'(pop_w);
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Serial configuration word and result frame of the converter
module ascr_config_register #(
	parameter int SAMPLE_W = ascr_pkg::SAMPLE_W,
	parameter int FIFO_DEPTH = ascr_pkg::FIFO_DEPTH
)(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	output logic dout_o,
	output logic dout_oe_o,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	input wire logic [SAMPLE_W-1:0] sample_data_i,
	output logic conv_start_o,
	output logic shutdown_o,
	output logic awake_o,
	output ascr_pkg::ascr_status_type status_o
);
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic sclk_d_r;
	logic cs_n_d_r;
	ascr_pkg::ascr_frame_type state_r;
	logic [4:0] cnt_r;
	logic [11:0] cap_r;
	logic [15:0] sh_r;
	logic [15:0] frame_r;
	ascr_pkg::ascr_cfg_type cfg_r;
	logic pat_load_r;
	logic seq_on_r;
	logic seq_pat_r;
	logic [2:0] seq_last_r;
	logic [3:0] pos_r;
	logic [15:0] pattern_r;
	logic [2:0] mux_r;
	logic shutdown_r;
	logic [7:0] wake_cnt_r;
	wire sclk_s;
	wire cs_n_s;
	wire din_s;
	wire cs_fall_w;
	wire cs_rise_w;
	wire fall_w;
	wire mux_evt_w;
	wire commit_w;
	wire [1:0] mode_w;
	wire [15:0] prov_pat_w;
	wire [4:0] pat_adv_w;
	wire [4:0] pat_first_w;
	wire [2:0] consec_next_w;
	wire fifo_valid_w;
	wire [SAMPLE_W-1:0] fifo_data_w;
	wire [SAMPLE_W-1:0] coded_w;
	ascr_pkg::ascr_cfg_type cap_cfg_w;

	// Next set position after 'from' in a pattern; position i maps to bit 15-i
	function automatic logic [4:0] next_pos(input logic [15:0] pat, input logic [3:0] from);
		logic [4:0] res;
		logic [3:0] idx;
		res = 5'h00;
		for (int i = 16; i >= 1; i--)
		begin
			idx = from + 4'(i);
			if (pat[4'hF - idx])
				res = {1'b1, idx};
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: sclk, cs_n, din pass two flops, edges found on stage two
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			sync1_r <= 3'h3;
			sync2_r <= 3'h3;
			sclk_d_r <= 1'b1;
			cs_n_d_r <= 1'b1;
		end
		else
		begin
			sync1_r <= {din_i, cs_n_i, sclk_i};
			sync2_r <= sync1_r;
			sclk_d_r <= sclk_s;
			cs_n_d_r <= cs_n_s;
		end
	end

	assign sclk_s = sync2_r[0];
	assign cs_n_s = sync2_r[1];
	assign din_s = sync2_r[2];
	assign cs_fall_w = cs_n_d_r && !cs_n_s;
	assign cs_rise_w = !cs_n_d_r && cs_n_s;
	// Serial input is sampled on the falling clock edge only inside a frame
	assign fall_w = sclk_d_r && !sclk_s && (state_r == ascr_pkg::FR_SHIFT);
	assign mux_evt_w = fall_w && (cnt_r == ascr_pkg::MUX_EDGE_IDX);
	assign commit_w = fall_w && (cnt_r == ascr_pkg::LAST_EDGE_IDX);

	////////////////////////////////////////////////////////////////////////////
	// Frame state and falling-edge counter; a short frame commits nothing
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= ascr_pkg::FR_IDLE;
			cnt_r <= 5'h00;
		end
		else if (cs_fall_w)
		begin
			state_r <= ascr_pkg::FR_SHIFT;
			cnt_r <= 5'h00;
		end
		else if (cs_rise_w)
			state_r <= ascr_pkg::FR_IDLE;
		else if (fall_w)
		begin
			cnt_r <= cnt_r + 5'h01;
			if (cnt_r == ascr_pkg::LAST_EDGE_IDX)
				state_r <= ascr_pkg::FR_TAIL;
		end
	end

	// Capture shifts from the low end, so the first bit ends up in bit 11
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			cap_r <= 12'h000;
			sh_r <= 16'h0000;
		end
		else if (fall_w)
		begin
			if (cnt_r < ascr_pkg::CAP_EDGES)
				cap_r <= {cap_r[10:0], din_s};
			sh_r <= {sh_r[14:0], din_s};
		end
	end

	assign cap_cfg_w = cap_r;
	assign mode_w = {cap_cfg_w.sequencer_control_bit, cap_cfg_w.pattern_sel};

	////////////////////////////////////////////////////////////////////////////
	// Applied word: loaded at conversion end only when the gate bit is set
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			cfg_r <= ascr_pkg::CFG_RESET;
			pat_load_r <= 1'b0;
		end
		else if (commit_w)
		begin
			if (pat_load_r)
				pat_load_r <= 1'b0;
			else if (cap_cfg_w.write_gate)
			begin
				cfg_r <= cap_cfg_w;
				pat_load_r <= (mode_w == ascr_pkg::SEQ_LOAD_PAT);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: the pattern transfer is still two bits short on the 14th edge,
	// so the mux is steered from a provisional copy and the full one lands later
	// The 14th bit is still on the synchronised line, not yet in the shifter
	assign prov_pat_w = {sh_r[12:0], din_s, 2'b00};
	assign pat_first_w = next_pos(prov_pat_w, 4'hF);
	assign pat_adv_w = next_pos(pattern_r, pos_r);
	assign consec_next_w = (mux_r == seq_last_r) ? 3'h0 : mux_r + 3'h1;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			seq_on_r <= 1'b0;
			seq_pat_r <= 1'b0;
			seq_last_r <= 3'h0;
			pos_r <= 4'h0;
			pattern_r <= 16'h0000;
			mux_r <= 3'h0;
		end
		else if (commit_w && pat_load_r)
			pattern_r <= {sh_r[14:0], din_s};
		else if (mux_evt_w)
		begin
			if (pat_load_r)
			begin
				pattern_r <= prov_pat_w;
				seq_on_r <= pat_first_w[4];
				seq_pat_r <= 1'b1;
				pos_r <= pat_first_w[3:0];
				if (pat_first_w[4])
					mux_r <= pat_first_w[2:0];
			end
			else if (cap_cfg_w.write_gate && (mode_w != ascr_pkg::SEQ_CONTINUE || !seq_on_r))
			begin
				// Address value is the channel number itself
				seq_on_r <= (mode_w == ascr_pkg::SEQ_CONSEC);
				seq_pat_r <= 1'b0;
				seq_last_r <= cap_cfg_w.channel_address;
				mux_r <= (mode_w == ascr_pkg::SEQ_CONSEC) ? 3'h0 : cap_cfg_w.channel_address;
			end
			else if (seq_on_r && seq_pat_r)
			begin
				pos_r <= pat_adv_w[3:0];
				mux_r <= pat_adv_w[2:0];
			end
			else if (seq_on_r)
				mux_r <= consec_next_w;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result frame: one zero, three address bits, twelve result bits
	ascr_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(sample_valid_i),
		.in_ready_o(sample_ready_o),
		.in_data_i(sample_data_i),
		.out_valid_o(fifo_valid_w),
		.out_ready_i(cs_fall_w),
		.out_data_o(fifo_data_w)
	);

	// Front end delivers straight binary; an empty buffer yields a zero code
	assign coded_w = cfg_r.coding_sel ? fifo_data_w : {~fifo_data_w[SAMPLE_W-1], fifo_data_w[SAMPLE_W-2:0]};

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			frame_r <= 16'h0000;
		else if (cs_fall_w)
			frame_r <= fifo_valid_w ? {1'b0, mux_r, coded_w} : {1'b0, mux_r, 12'h000};
		else if (fall_w)
			frame_r <= {frame_r[14:0], 1'b0};
	end

	assign dout_o = frame_r[15];
	assign dout_oe_o = (state_r != ascr_pkg::FR_IDLE);
	assign conv_start_o = cs_fall_w;

	////////////////////////////////////////////////////////////////////////////
	// Power modes; auto shutdown drops after each conversion, wakes on select
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			shutdown_r <= 1'b0;
			wake_cnt_r <= 8'h00;
		end
		else
		begin
			if (cfg_r.power_mode_bits == ascr_pkg::PM_FULL_SD)
				shutdown_r <= 1'b1;
			else if (cfg_r.power_mode_bits != ascr_pkg::PM_AUTO_SD)
				shutdown_r <= 1'b0;
			else if (cs_fall_w)
				shutdown_r <= 1'b0;
			else if (commit_w)
				shutdown_r <= 1'b1;
			if (shutdown_r)
				wake_cnt_r <= ascr_pkg::WAKE_CYC;
			else if (wake_cnt_r != 8'h00)
				wake_cnt_r <= wake_cnt_r - 8'h01;
		end
	end

	assign shutdown_o = shutdown_r;
	assign awake_o = !shutdown_r && (wake_cnt_r == 8'h00);
	// Span and coding reach the analog side only through the applied word
	assign status_o = {mux_r, cfg_r.power_mode_bits, cfg_r.span_sel, cfg_r.coding_sel, seq_on_r};

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_cnt_restart;
		cs_fall_w |=> (cnt_r == 5'h00) && (state_r == ascr_pkg::FR_SHIFT);
	endproperty
	a_cnt_restart: assert property (p_cnt_restart) else $error("counter not restarted at select");

	property p_cap_freeze;
		(fall_w && cnt_r >= ascr_pkg::CAP_EDGES) |=> $stable(cap_r);
	endproperty
	a_cap_freeze: assert property (p_cap_freeze) else $error("capture moved after twelfth edge");

	property p_first_bit;
		(fall_w && cnt_r == 5'h00) |=> cap_r[0] == $past(din_s);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first bit not captured at low end");

	property p_load;
		(commit_w && !pat_load_r && cap_r[11]) |=> cfg_r == $past(cap_r);
	endproperty
	a_load: assert property (p_load) else $error("gated word not applied");

	property p_hold;
		(commit_w && !cap_r[11]) |=> $stable(cfg_r);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed with gate clear");

	property p_mux_edge;
		$changed(mux_r) |-> $past(fall_w) && ($past(cnt_r) == ascr_pkg::MUX_EDGE_IDX);
	endproperty
	a_mux_edge: assert property (p_mux_edge) else $error("mux moved off the 14th edge");

	property p_addr_out;
		cs_fall_w |=> (frame_r[15] == 1'b0) && (frame_r[14:12] == $past(mux_r));
	endproperty
	a_addr_out: assert property (p_addr_out) else $error("frame lacks channel address");

	property p_full_sd;
		(cfg_r.power_mode_bits == ascr_pkg::PM_FULL_SD) |=> shutdown_o ##1 !awake_o;
	endproperty
	a_full_sd: assert property (p_full_sd) else $error("full shutdown not entered");

	property p_consec_start;
		(mux_evt_w && !pat_load_r && cap_r[11] && mode_w == ascr_pkg::SEQ_CONSEC) |=> (mux_r == 3'h0) && seq_on_r;
	endproperty
	a_consec_start: assert property (p_consec_start) else $error("consecutive run not from zero");

	c_gated_load: cover property (commit_w && cap_r[11]);
	c_pat_load: cover property (commit_w && pat_load_r);
	c_consec: cover property (seq_on_r && !seq_pat_r && $changed(mux_r));
	c_auto_sd: cover property ($rose(shutdown_r) && cfg_r.power_mode_bits == ascr_pkg::PM_AUTO_SD);
endmodule

`default_nettype wire

// >>> hw/ascr_pkg.sv
package ascr_pkg;

	// Configuration word layout, sent most significant bit first
	typedef struct packed
	{
		logic write_gate;
		logic sequencer_control_bit;
		logic ignored_bit_hi;
		logic [2:0] channel_address;
		logic [1:0] power_mode_bits;
		logic pattern_sel;
		logic ignored_bit_lo;
		logic span_sel;
		logic coding_sel;
	} ascr_cfg_type;

	// Outward view of the applied configuration
	typedef struct packed
	{
		logic [2:0] mux_channel;
		logic [1:0] power_mode;
		logic span_sel;
		logic coding_sel;
		logic seq_active;
	} ascr_status_type;

	typedef enum logic [1:0]
	{
		FR_IDLE = 2'b00,
		FR_SHIFT = 2'b01,
		FR_TAIL = 2'b11
	} ascr_frame_type;

	localparam int CFG_W = 12;
	localparam int SAMPLE_W = 12;
	localparam int FRAME_LEN = 16;
	localparam int FIFO_DEPTH = 32;
	localparam logic [4:0] CAP_EDGES = 5'h0C;
	localparam logic [4:0] MUX_EDGE_IDX = 5'h0D;
	localparam logic [4:0] LAST_EDGE_IDX = 5'h0F;
	localparam logic [4:0] FRAME_EDGES = 5'h10;
	localparam logic [11:0] CFG_RESET = 12'h030;
	localparam logic [1:0] PM_NORMAL = 2'h3;
	localparam logic [1:0] PM_FULL_SD = 2'h2;
	localparam logic [1:0] PM_AUTO_SD = 2'h1;
	localparam logic [1:0] SEQ_NONE = 2'h0;
	localparam logic [1:0] SEQ_LOAD_PAT = 2'h1;
	localparam logic [1:0] SEQ_CONTINUE = 2'h2;
	localparam logic [1:0] SEQ_CONSEC = 2'h3;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAKE_NS = 1000;
	localparam logic [7:0] WAKE_CYC = 8'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// >>> verification/ascr_host_model.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Host serial port: frames of 16 clocks at 160 ns, data moved on the rising edge
module ascr_host_model
(
	input wire logic sys_clk_i,
	input wire logic dout_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o
);
	// Idle link: clock parked high, select high
	initial
	begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end

	// Released data line shows no stale bit between frames
	always @(posedge sys_clk_i)
	begin
		if (cs_n_o)
			din_o <= ~din_o;
	end

	// One frame; fewer than 16 falls cuts it short on purpose
	task automatic xfer(input logic [15:0] word, input int falls, output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge sys_clk_i);
		cs_n_o <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		for (int i = 0; i < falls; i++)
		begin
			din_o <= word[15-i];
			sclk_o <= 1'b1;
			repeat (8) @(posedge sys_clk_i);
			rx[15-i] = dout_i;
			sclk_o <= 1'b0;
			repeat (8) @(posedge sys_clk_i);
		end
		cs_n_o <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
	endtask
endmodule

`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Bench: host model on the link, samples pushed by hand
module tb;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sclk, cs_n, din, dout, oe, rdy, sd, aw, cst;
	int starts = 0;
	logic v = 1'b0;
	logic [11:0] d = 12'h000;
	logic [15:0] rx;
	int errors = 0;
	int checks = 0;
	ascr_pkg::ascr_status_type st_o;

	// Clock at 100 MHz
	always #5 sys_clk_i = ~sys_clk_i;

	// Count conversion starts; a one-cycle pulse counts once per frame
	always @(posedge sys_clk_i)
	begin
		if (cst === 1'b1)
			starts <= starts + 1;
	end

	ascr_host_model u_ascr_host_model (.sys_clk_i(sys_clk_i), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n),
		.din_o(din));
	ascr_config_register u_ascr_config_register (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .din_i(din), .dout_o(dout), .dout_oe_o(oe), .sample_valid_i(v), .sample_ready_o(rdy),
		.sample_data_i(d), .conv_start_o(cst), .shutdown_o(sd), .awake_o(aw), .status_o(st_o));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [15:0] wd(input logic [1:0] sq, input logic [2:0] a, input logic [1:0] pm,
		input logic sp, input logic cd);
		return {1'b1, sq[1], 1'b0, a, pm, sq[0], 1'b0, sp, cd, 4'h0};
	endfunction

	function automatic logic [15:0] sv(input logic [2:0] m, input logic [1:0] pm, input logic sp, input logic cd,
		input logic sq);
		return {8'h00, m, pm, sp, cd, sq};
	endfunction

	task automatic print_verdict;
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic x(input logic [15:0] w);
		u_ascr_host_model.xfer(w, 16, rx);
	endtask

	// Valid is held until the edge that takes it; a stuck ready ends the run
	task automatic push(input logic [11:0] val);
		int n = 0;
		@(posedge sys_clk_i);
		v <= 1'b1;
		d <= val;
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while (rdy !== 1'b1 && n < 50);
		v <= 1'b0;
		if (n >= 50)
		begin
			errors++;
			print_verdict();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Gated write lands at frame end; tail bits ignored; mux moves on the 14th edge of the same frame
	task automatic t_write;
		push(12'h123);
		fork
			x(wd(2'h0, 3'h5, 2'h3, 1'b1, 1'b1) | 16'h000F);
			begin
				repeat (216) @(posedge sys_clk_i);
				chk({12'h000, st_o.mux_channel, oe}, 16'h0001);
				repeat (20) @(posedge sys_clk_i);
				chk({13'h0000, st_o.mux_channel}, 16'h0005);
			end
		join
		chk(rx, 16'h0923);
		chk(16'(starts), 16'h0001);
		chk({8'h00, st_o}, sv(3'h5, 2'h3, 1'b1, 1'b1, 1'b0));
		x(wd(2'h3, 3'h2, 2'h2, 1'b0, 1'b0) & 16'h7FFF);
		chk(rx, 16'h5000);
		chk(16'(starts), 16'h0002);
		chk({8'h00, st_o}, sv(3'h5, 2'h3, 1'b1, 1'b1, 1'b0));
	endtask

	// Fill the buffer until it refuses, then drain one sample per frame past empty
	task automatic t_fifo;
		for (int i = 0; i < 32; i++)
			push(12'h100 + 12'(i));
		@(posedge sys_clk_i);
		chk({15'h0000, rdy}, 16'h0000);
		for (int i = 0; i < 33; i++)
		begin
			x(16'h0000);
			chk(rx, {4'h5, (i < 32) ? 12'h100 + 12'(i) : 12'h000});
		end
	endtask

	// Full shutdown keeps the word; auto shutdown sleeps after a frame, wakes in 1 us
	task automatic t_power;
		x(wd(2'h0, 3'h5, 2'h2, 1'b1, 1'b1));
		x(16'h0000);
		chk({14'h0000, sd, aw}, 16'h0002);
		chk({8'h00, st_o}, sv(3'h5, 2'h2, 1'b1, 1'b1, 1'b0));
		x(wd(2'h0, 3'h5, 2'h1, 1'b1, 1'b1));
		chk({14'h0000, sd, aw}, 16'h0002);
		x(16'h0000);
		chk({14'h0000, sd, aw}, 16'h0002);
		fork
			x(wd(2'h0, 3'h5, 2'h3, 1'b1, 1'b1));
			begin
				repeat (12) @(posedge sys_clk_i);
				chk({14'h0000, sd, aw}, 16'h0000);
				repeat (110) @(posedge sys_clk_i);
				chk({14'h0000, sd, aw}, 16'h0001);
			end
		join
		// Last auto-mode conversion still sleeps; the host then allows the wake time
		chk({14'h0000, sd, aw}, 16'h0000);
		repeat (110) @(posedge sys_clk_i);
		chk({14'h0000, sd, aw}, 16'h0001);
	endtask

	// Consecutive run from 0, then a loaded pattern kept across gate-off and continue writes
	task automatic t_seq;
		logic [15:0] f[9];
		logic [2:0] m[9];
		f = '{wd(2'h3, 3'h2, 2'h3, 1'b1, 1'b1), 16'h0000, 16'h0000, 16'h0000, 16'h0000,
			wd(2'h1, 3'h3, 2'h3, 1'b1, 1'b1), 16'h2400, 16'h0000, wd(2'h2, 3'h3, 2'h3, 1'b1, 1'b1)};
		m = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h1, 3'h7, 3'h2, 3'h5, 3'h2}; // Channel 7 marks an unchecked frame
		for (int i = 0; i < 9; i++)
		begin
			x(f[i]);
			if (m[i] != 3'h7)
				chk({12'h000, st_o.mux_channel, st_o.seq_active}, {12'h000, m[i], 1'b1});
		end
	endtask

	// A frame cut short loads nothing; the next one starts from bit 11 again
	task automatic t_restart;
		u_ascr_host_model.xfer(wd(2'h0, 3'h6, 2'h3, 1'b0, 1'b0), 5, rx);
		chk({14'h0000, st_o.span_sel, st_o.coding_sel}, 16'h0003);
		x(wd(2'h0, 3'h6, 2'h3, 1'b0, 1'b1));
		chk({13'h0000, st_o.span_sel, st_o.coding_sel, st_o.seq_active}, 16'h0002);
	endtask

	// Reset for three cycles, then the scenarios in order
	initial
	begin
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		chk({8'h00, st_o}, sv(3'h0, 2'h3, 1'b0, 1'b0, 1'b0));
		chk({13'h0000, sd, aw, oe}, 16'h0002);
		t_write();
		t_fifo();
		t_power();
		t_seq();
		t_restart();
		print_verdict();
	end
endmodule

`default_nettype wire
